// ---- hdl/lfm_consts.svh ----
// Register map, field positions and reset values of the LED fault monitor.
// Included by every design file that decodes registers or fields.
`ifndef LFM_CONSTS_SVH
`define LFM_CONSTS_SVH

// Register offsets
`define LFM_A_TEMP_CFG   8'h7A
`define LFM_A_SW_CFG0    8'h84
`define LFM_A_SHORT_L    8'h90
`define LFM_A_SHORT_H    8'h91
`define LFM_A_OPEN_L     8'h92
`define LFM_A_OPEN_H     8'h93
`define LFM_A_SUMMARY    8'h94
`define LFM_A_MASK       8'h96
`define LFM_A_CRC_CNT    8'h98
`define LFM_A_I2C_STAT   8'hB0
`define LFM_A_DUTY_CTRL  8'hB1
`define LFM_A_STATE      8'hB2
`define LFM_A_DUTY_L     8'hC3
`define LFM_A_DUTY_H     8'hC4

// Per-switch configuration fields
`define LFM_CFG_OPEN_TH_LSB  0
`define LFM_CFG_SHORT_TH_LSB 2
`define LFM_CFG_OPEN_EN_BIT  6
`define LFM_CFG_SHORT_EN_BIT 7

// Summary and report mask bit positions
`define LFM_B_OPEN   0
`define LFM_B_SHORT  1
`define LFM_B_ALARM  2
`define LFM_B_TSD    3
`define LFM_B_CRC    4
`define LFM_B_COMM   5
`define LFM_B_I2C    6
`define LFM_B_DUTY   7

// I2C status bits
`define LFM_I2C_NACK_BIT     0
`define LFM_I2C_MISMATCH_BIT 1

// Reset value and CRC count limit
`define LFM_RST_BYTE   8'h00
`define LFM_CRC_MAX    8'hFF

`endif

// ---- hdl/lfm_pkg.sv ----
// Types shared by the LED fault monitor modules.
// Constants live in lfm_consts.svh; this package holds types only.
package lfm_pkg;

   typedef logic [7:0] lfm_byte_t;

   typedef enum logic [1:0] {
      LFM_COMM_RUN  = 2'b01,
      LFM_COMM_SAFE = 2'b10
   } lfm_comm_e;

   typedef enum logic [1:0] {
      LFM_TH_RUN   = 2'b01,
      LFM_TH_BLOCK = 2'b10
   } lfm_therm_e;

endpackage : lfm_pkg

// ---- hdl/lfm_sw_if.sv ----
// Signals between the fault core and the bypass switch monitor.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface lfm_sw_if #(parameter int NUM_SW = 12);
   logic              tsd_block;
   logic              pwm_start;
   logic              on_end;
   logic [NUM_SW-1:0] open_cmp;
   logic [NUM_SW-1:0] short_cmp;
   logic [NUM_SW-1:0] on_req;
   logic [NUM_SW-1:0] open_evt;
   logic [NUM_SW-1:0] short_evt;
   logic [NUM_SW-1:0] bypass;

   modport core (output tsd_block, pwm_start, on_end, open_cmp, short_cmp, on_req,
                 input  open_evt, short_evt, bypass);
   modport mon  (input  tsd_block, pwm_start, on_end, open_cmp, short_cmp, on_req,
                 output open_evt, short_evt, bypass);
endinterface : lfm_sw_if

// ---- hdl/lfm_sync.sv ----
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
module lfm_sync
   import lfm_pkg::*;
#(
   parameter int W = 1
)(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // Levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lfm_sync_s;

   lfm_sync_s r_reg;
   lfm_sync_s r_next;

   always_comb begin
      r_next.s1 = async_i;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sync_o = r_reg.s2;

endmodule : lfm_sync

// ---- hdl/lfm_sw_mon.sv ----
// Per-switch open/short detection and bypass gate command.
// Assumes comparator inputs are already synchronised by the core.
`timescale 1ns/1ps
module lfm_sw_mon
   import lfm_pkg::*;
#(
   parameter int NUM_SW = 12
)(
   // Clock and reset (active high, includes undervoltage)
   input  wire logic clk_i,
   input  wire logic clear_i,
   // Core side
   lfm_sw_if.mon     sw
);

   typedef struct packed {
      logic [NUM_SW-1:0] hold;
      logic [NUM_SW-1:0] bypass;
   } lfm_mon_s;

   lfm_mon_s r_reg;
   lfm_mon_s r_next;

   always_comb begin
      r_next = r_reg;
      // Open switch held on until the next PWM cycle starts
      r_next.hold = (r_reg.hold & ~{NUM_SW{sw.pwm_start}}) | sw.open_cmp;
      // Thermal shutdown overrides every on request, open hold included
      r_next.bypass = sw.tsd_block ? '0 : (sw.on_req | r_next.hold);
   end

   always_ff @(posedge clk_i) begin
      if (clear_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sw.open_evt  = sw.open_cmp;
   assign sw.short_evt = sw.short_cmp & {NUM_SW{sw.on_end}};
   assign sw.bypass    = r_reg.bypass;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (clear_i);

   open_bypass_a: assert property (
      !sw.tsd_block |=> ((sw.bypass & $past(sw.open_cmp)) == $past(sw.open_cmp)))
      else $error("open switch not bypassed");

   open_hold_a: assert property (
      (sw.open_cmp != '0) ##1 (!sw.pwm_start && !sw.tsd_block)[*2]
      |=> ((sw.bypass & $past(sw.open_cmp, 3)) == $past(sw.open_cmp, 3)))
      else $error("open hold dropped before pwm cycle start");

   tsd_all_off_a: assert property (
      sw.tsd_block |=> (sw.bypass == '0))
      else $error("switch on during thermal shutdown");

endmodule : lfm_sw_mon

// ---- hdl/lfm_top.sv ----
// Fault detection, latching, masking and reporting for twelve LED bypass switches.
// Assumes comparators, temperature and supply monitors are asynchronous levels,
// and protocol, PWM and loopback events are single-cycle pulses on clk_i.
//
// Notes on behaviour
// - Open detected: bypass switch turns on and holds until next PWM cycle.
// - Open detection sets the switch bit in low/high open flag registers.
// - Open summary flag and fault output need flag enable and mask both set.
// - Each switch selects open threshold 5V, 10V, 15V or 20V by two bits.
// - Short comparator sampled at LED on end; sets switch short flag bit.
// - Short summary flag and fault output need flag enable and mask both set.
// - Four-bit short threshold per switch, 1V to 16V in 1V steps.
// - Flags stay set; host clears by writing 0; output releases when clear.
// - Switch operation recovers by itself once fault condition goes away.
// - Temperature above selected alarm level sets alarm flag; reported if masked in.
// - Alarm flag latched until host writes 0; output released only then.
// - Shutdown temperature forces all switches off, sets shutdown flag, reports.
// - Switches blocked until below restart level; shutdown flag latched until cleared.
// - CRC mismatch increments error count and sets CRC flag, cleared by 0.
// - Watchdog timeout with fail-safe and no good traffic enters fail-safe.
// - I2C no acknowledge or mismatch sets its flag and I2C summary flag.
// - With duty check on, duty deviation sets channel and summary duty flags.
// - Undervoltage turns all LEDs on and resets every register.
// - Masks gate the fault output and the open and short summary flags; detection and other flags keep running.
// - Any reportable fault sets its summary bit and pulls the output low.
`timescale 1ns/1ps
`include "lfm_consts.svh"
module lfm_top
   import lfm_pkg::*;
#(
   parameter int NUM_SW = 12
)(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   // Register port
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   // Analog monitors, asynchronous
   input  wire logic [NUM_SW-1:0] open_cmp_i,
   input  wire logic [NUM_SW-1:0] short_cmp_i,
   input  wire logic [3:0]        temp_above_lvl_i,
   input  wire logic              tsd_hot_i,
   input  wire logic              tsd_cool_i,
   input  wire logic              uvlo_i,
   input  wire logic              failsafe_strap_i,
   // PWM and protocol events, on clk_i
   input  wire logic              pwm_cycle_start_i,
   input  wire logic              led_on_end_i,
   input  wire logic [NUM_SW-1:0] pwm_on_req_i,
   input  wire logic              crc_err_i,
   input  wire logic              wd_timeout_i,
   input  wire logic              error_free_i,
   input  wire logic              update_cmd_i,
   input  wire logic              i2c_nack_i,
   input  wire logic              i2c_mismatch_i,
   input  wire logic [NUM_SW-1:0] duty_err_i,
   // Switch and analog control
   output logic [NUM_SW-1:0]      bypass_on_o,
   output logic [2*NUM_SW-1:0]    open_threshold_sel_o,
   output logic [4*NUM_SW-1:0]    short_threshold_sel_o,
   output logic [1:0]             temp_alarm_level_o,
   output logic                   failsafe_o,
   // Open-drain fault report pin
   output logic                   fault_report_n_o,
   output logic                   fault_report_oe_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter check and synchronisers

   generate
      if (NUM_SW < 1 || NUM_SW > 16) begin : g_bad_num
         $error("lfm_top: NUM_SW must lie in 1..16");
      end
   endgenerate

   localparam int AW = 2 * NUM_SW + 8;

   logic [AW-1:0]     async_vec;
   logic [AW-1:0]     sync_vec;
   logic [NUM_SW-1:0] open_cmp_s;
   logic [NUM_SW-1:0] short_cmp_s;
   logic [3:0]        temp_above_s;
   logic              tsd_hot_s;
   logic              tsd_cool_s;
   logic              uvlo_s;
   logic              strap_s;
   logic              core_clr;

   assign async_vec = {failsafe_strap_i, uvlo_i, tsd_cool_i, tsd_hot_i, temp_above_lvl_i,
                       short_cmp_i, open_cmp_i};

   lfm_sync #(.W(AW)) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (async_vec),
      .sync_o   (sync_vec)
   );

   assign {strap_s, uvlo_s, tsd_cool_s, tsd_hot_s, temp_above_s, short_cmp_s, open_cmp_s}
      = sync_vec;

   // Undervoltage acts as a reset of all registers and turns every LED on
   assign core_clr = !resetn_i || uvlo_s;

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [NUM_SW-1:0][7:0] sw_cfg;
      logic [NUM_SW-1:0]      short_fl;
      logic [NUM_SW-1:0]      open_fl;
      logic [NUM_SW-1:0]      duty_fl;
      lfm_byte_t              sum;
      lfm_byte_t              mask;
      logic [1:0]             temp_lvl;
      lfm_byte_t              crc_cnt;
      logic [1:0]             i2c_fl;
      logic                   duty_en;
      lfm_comm_e              comm;
      lfm_therm_e             therm;
      lfm_byte_t              rdata;
      logic                   report;
   } lfm_state_s;

   lfm_state_s r_reg;
   lfm_state_s r_next;

   lfm_sw_if #(.NUM_SW(NUM_SW)) sw ();

   lfm_sw_mon #(.NUM_SW(NUM_SW)) u_sw_mon (
      .clk_i   (clk_i),
      .clear_i (core_clr),
      .sw      (sw.mon)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register helpers

   // Byte-wise write-zero-to-clear keep mask for a low/high register pair
   function automatic logic [15:0] keep16(input logic wr, input logic [7:0] a,
                                          input logic [7:0] d, input logic [7:0] lo);
      logic [15:0] k;
      k = 16'hFFFF;
      if (wr && a == lo) begin
         k[7:0] = d;
      end
      if (wr && a == 8'(lo + 8'h01)) begin
         k[15:8] = d;
      end
      return k;
   endfunction : keep16

   function automatic lfm_byte_t flag_byte(input logic [NUM_SW-1:0] v, input logic hi);
      logic [15:0] t;
      t = '0;
      t[NUM_SW-1:0] = v;
      return hi ? t[15:8] : t[7:0];
   endfunction : flag_byte

   logic [15:0]       keep_short;
   logic [15:0]       keep_open;
   logic [15:0]       keep_duty;
   logic [NUM_SW-1:0] open_en;
   logic [NUM_SW-1:0] short_en;
   logic              wr_sum;
   logic              wr_i2c;
   lfm_byte_t         sum_set;
   lfm_byte_t         sum_keep;
   lfm_byte_t         rd_mux;
   logic              alarm_now;

   always_comb begin
      keep_short = keep16(reg_wr_i, reg_addr_i, reg_wdata_i, `LFM_A_SHORT_L);
      keep_open  = keep16(reg_wr_i, reg_addr_i, reg_wdata_i, `LFM_A_OPEN_L);
      keep_duty  = keep16(reg_wr_i, reg_addr_i, reg_wdata_i, `LFM_A_DUTY_L);
      wr_sum     = reg_wr_i && reg_addr_i == `LFM_A_SUMMARY;
      wr_i2c     = reg_wr_i && reg_addr_i == `LFM_A_I2C_STAT;
      for (int i = 0; i < NUM_SW; i++) begin
         open_en[i]  = r_reg.sw_cfg[i][`LFM_CFG_OPEN_EN_BIT];
         short_en[i] = r_reg.sw_cfg[i][`LFM_CFG_SHORT_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      r_next    = r_reg;
      alarm_now = temp_above_s[r_reg.temp_lvl];
      sum_set   = '0;
      // Open and short summary bits need both the enable and the mask
      sum_set[`LFM_B_OPEN]  = |(sw.open_evt & open_en) && r_reg.mask[`LFM_B_OPEN];
      sum_set[`LFM_B_SHORT] = |(sw.short_evt & short_en) && r_reg.mask[`LFM_B_SHORT];
      // The remaining flags set regardless of mask
      sum_set[`LFM_B_ALARM] = alarm_now;
      sum_set[`LFM_B_TSD]   = tsd_hot_s;
      sum_set[`LFM_B_CRC]   = crc_err_i;
      sum_set[`LFM_B_COMM]  = wd_timeout_i && strap_s && !error_free_i;
      sum_set[`LFM_B_I2C]   = i2c_nack_i || i2c_mismatch_i;
      sum_set[`LFM_B_DUTY]  = r_reg.duty_en && (|duty_err_i);
      sum_keep = wr_sum ? reg_wdata_i : 8'hFF;

      // Sticky flags: a set in the clearing cycle wins
      r_next.sum      = (r_reg.sum & sum_keep) | sum_set;
      r_next.open_fl  = (r_reg.open_fl & keep_open[NUM_SW-1:0]) | sw.open_evt;
      r_next.short_fl = (r_reg.short_fl & keep_short[NUM_SW-1:0]) | sw.short_evt;
      r_next.duty_fl  = (r_reg.duty_fl & keep_duty[NUM_SW-1:0])
                      | (duty_err_i & {NUM_SW{r_reg.duty_en}});
      r_next.i2c_fl   = r_reg.i2c_fl & (wr_i2c ? reg_wdata_i[1:0] : 2'b11);
      r_next.i2c_fl[`LFM_I2C_NACK_BIT]     = r_next.i2c_fl[`LFM_I2C_NACK_BIT]
                                             || i2c_nack_i;
      r_next.i2c_fl[`LFM_I2C_MISMATCH_BIT] = r_next.i2c_fl[`LFM_I2C_MISMATCH_BIT]
                                             || i2c_mismatch_i;

      // Saturates so a stuck link cannot wrap the count back to small values
      if (crc_err_i && r_reg.crc_cnt != `LFM_CRC_MAX) begin
         r_next.crc_cnt = 8'(r_reg.crc_cnt + 8'h01);
      end

      // Configuration writes
      if (reg_wr_i) begin
         for (int i = 0; i < NUM_SW; i++) begin
            if (reg_addr_i == 8'(`LFM_A_SW_CFG0 + i)) begin
               r_next.sw_cfg[i] = reg_wdata_i;
            end
         end
         case (reg_addr_i)
            `LFM_A_TEMP_CFG:  r_next.temp_lvl = reg_wdata_i[1:0];
            `LFM_A_MASK:      r_next.mask     = reg_wdata_i;
            `LFM_A_DUTY_CTRL: r_next.duty_en  = reg_wdata_i[0];
            default: begin
            end
         endcase
      end

      // Fail-safe entry and exit
      case (r_reg.comm)
         LFM_COMM_RUN: begin
            if (sum_set[`LFM_B_COMM]) begin
               r_next.comm = LFM_COMM_SAFE;
            end
         end
         LFM_COMM_SAFE: begin
            if (update_cmd_i) begin
               r_next.comm = LFM_COMM_RUN;
            end
         end
         default: r_next.comm = LFM_COMM_RUN;
      endcase

      // Restart only below the hysteresis level, whatever the flag state
      case (r_reg.therm)
         LFM_TH_RUN: begin
            if (tsd_hot_s) begin
               r_next.therm = LFM_TH_BLOCK;
            end
         end
         LFM_TH_BLOCK: begin
            if (tsd_cool_s && !tsd_hot_s) begin
               r_next.therm = LFM_TH_RUN;
            end
         end
         default: r_next.therm = LFM_TH_BLOCK;
      endcase

      // Read data, unmapped offsets read zero
      rd_mux = '0;
      for (int i = 0; i < NUM_SW; i++) begin
         if (reg_addr_i == 8'(`LFM_A_SW_CFG0 + i)) begin
            rd_mux = r_reg.sw_cfg[i];
         end
      end
      case (reg_addr_i)
         `LFM_A_TEMP_CFG:  rd_mux = {6'h00, r_reg.temp_lvl};
         `LFM_A_SHORT_L:   rd_mux = flag_byte(r_reg.short_fl, 1'b0);
         `LFM_A_SHORT_H:   rd_mux = flag_byte(r_reg.short_fl, 1'b1);
         `LFM_A_OPEN_L:    rd_mux = flag_byte(r_reg.open_fl, 1'b0);
         `LFM_A_OPEN_H:    rd_mux = flag_byte(r_reg.open_fl, 1'b1);
         `LFM_A_SUMMARY:   rd_mux = r_reg.sum;
         `LFM_A_MASK:      rd_mux = r_reg.mask;
         `LFM_A_CRC_CNT:   rd_mux = r_reg.crc_cnt;
         `LFM_A_I2C_STAT:  rd_mux = {6'h00, r_reg.i2c_fl};
         `LFM_A_DUTY_CTRL: rd_mux = {7'h00, r_reg.duty_en};
         `LFM_A_STATE:     rd_mux = {6'h00, r_reg.comm == LFM_COMM_SAFE,
                                     r_reg.therm == LFM_TH_BLOCK};
         `LFM_A_DUTY_L:    rd_mux = flag_byte(r_reg.duty_fl, 1'b0);
         `LFM_A_DUTY_H:    rd_mux = flag_byte(r_reg.duty_fl, 1'b1);
         default: begin
         end
      endcase
      if (reg_rd_i) begin
         r_next.rdata = rd_mux;
      end

      // Open-drain report from masked summary flags
      r_next.report = |(r_reg.sum & r_reg.mask);
   end

   always_ff @(posedge clk_i) begin
      if (core_clr) begin
         r_reg          <= '0;
         r_reg.sw_cfg   <= {NUM_SW{`LFM_RST_BYTE}};
         r_reg.mask     <= `LFM_RST_BYTE;
         r_reg.comm     <= LFM_COMM_RUN;
         r_reg.therm    <= LFM_TH_RUN;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign sw.tsd_block = (r_reg.therm == LFM_TH_BLOCK);
   assign sw.pwm_start = pwm_cycle_start_i;
   assign sw.on_end    = led_on_end_i;
   assign sw.open_cmp  = open_cmp_s;
   assign sw.short_cmp = short_cmp_s;
   assign sw.on_req    = pwm_on_req_i;

   generate
      for (genvar g = 0; g < NUM_SW; g++) begin : g_thr
         assign open_threshold_sel_o[2*g +: 2]  =
            r_reg.sw_cfg[g][`LFM_CFG_OPEN_TH_LSB +: 2];
         assign short_threshold_sel_o[4*g +: 4] =
            r_reg.sw_cfg[g][`LFM_CFG_SHORT_TH_LSB +: 4];
      end
   endgenerate

   assign bypass_on_o        = sw.bypass;
   assign temp_alarm_level_o = r_reg.temp_lvl;
   assign failsafe_o         = (r_reg.comm == LFM_COMM_SAFE);
   assign reg_rdata_o        = r_reg.rdata;
   assign fault_report_oe_o  = r_reg.report;
   assign fault_report_n_o   = !r_reg.report;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (core_clr);

   short_flag_set_a: assert property (
      1'b1 |=> ((r_reg.short_fl & $past(sw.short_evt)) == $past(sw.short_evt)))
      else $error("short event not latched");

   open_sum_gate_a: assert property (
      $rose(r_reg.sum[`LFM_B_OPEN])
      |-> $past(|(sw.open_evt & open_en)) && $past(r_reg.mask[`LFM_B_OPEN]))
      else $error("open summary set without enable and mask");

   fault_pin_a: assert property (
      (|(r_reg.sum & r_reg.mask)) |=> fault_report_oe_o && !fault_report_n_o)
      else $error("fault pin not pulled low");

   fault_release_a: assert property (
      (r_reg.sum & r_reg.mask) == '0 |=> !fault_report_oe_o)
      else $error("fault pin held low with no reported flag");

   crc_count_a: assert property (
      crc_err_i && r_reg.crc_cnt != `LFM_CRC_MAX
      |=> r_reg.crc_cnt == 8'($past(r_reg.crc_cnt) + 8'h01) && r_reg.sum[`LFM_B_CRC])
      else $error("crc error not counted");

   alarm_sticky_a: assert property (
      r_reg.sum[`LFM_B_ALARM] && !(wr_sum && !reg_wdata_i[`LFM_B_ALARM])
      |=> r_reg.sum[`LFM_B_ALARM])
      else $error("alarm flag lost without clear");

   tsd_hold_a: assert property (
      r_reg.therm == LFM_TH_BLOCK && !tsd_cool_s |=> r_reg.therm == LFM_TH_BLOCK)
      else $error("restart before cooling");

   tsd_flag_a: assert property (
      tsd_hot_s |=> r_reg.sum[`LFM_B_TSD] ##1 bypass_on_o == '0)
      else $error("thermal shutdown not handled");

   failsafe_enter_a: assert property (
      wd_timeout_i && strap_s && !error_free_i
      |=> failsafe_o && r_reg.sum[`LFM_B_COMM])
      else $error("fail-safe not entered");

endmodule : lfm_top

// ---- verif/lfm_host_mon.sv ----
// Host-side view of the open-drain fault pin with its pull-up.
// Assumes oe high means the device pulls the pin low.
`timescale 1ns/1ps
module lfm_host_mon (
   // Pin drive from the device
   input  wire logic oe_i,
   input  wire logic n_i,
   // Level the host reads
   output logic      pin_o
);
   // Pull-up wins whenever the device lets go
   assign pin_o = oe_i ? n_i : 1'b1;
endmodule : lfm_host_mon

// ---- verif/led_fault_monitor_test.sv ----
// Self-checking bench for the LED fault monitor top.
// Assumes one 200 MHz clock and the one-cycle register port of the top.
`timescale 1ns/1ps
`include "lfm_consts.svh"
module led_fault_monitor_test;
   logic        clk_i, resetn_i, wr, rd, fpin, oe, fn, fs;
   logic        hot, cool, uvlo, strap, pst, onend, crc, wdt, efree, upd, nack, mism;
   logic [7:0]  addr, wdata, rdata;
   logic [11:0] ocmp, scmp, onreq, duty, byp;
   logic [3:0]  tlvl;
   logic [23:0] oth;
   logic [47:0] sth;
   logic [1:0]  tal;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cyc = 0;

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   lfm_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .open_cmp_i(ocmp),
      .short_cmp_i(scmp), .temp_above_lvl_i(tlvl), .tsd_hot_i(hot), .tsd_cool_i(cool),
      .uvlo_i(uvlo), .failsafe_strap_i(strap), .pwm_cycle_start_i(pst),
      .led_on_end_i(onend), .pwm_on_req_i(onreq), .crc_err_i(crc), .wd_timeout_i(wdt),
      .error_free_i(efree), .update_cmd_i(upd), .i2c_nack_i(nack),
      .i2c_mismatch_i(mism), .duty_err_i(duty), .bypass_on_o(byp),
      .open_threshold_sel_o(oth), .short_threshold_sel_o(sth),
      .temp_alarm_level_o(tal), .failsafe_o(fs), .fault_report_n_o(fn),
      .fault_report_oe_o(oe));
   lfm_host_mon i_host (.oe_i(oe), .n_i(fn), .pin_o(fpin));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Ends 1 ns past the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      rd <= 1'b0;
      tick(1);
      chk(rdata, e);
   endtask : rd_chk

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn_i, wr, rd, hot, cool, uvlo, strap, pst, onend, crc, wdt} = '0;
      {efree, upd, nack, mism, addr, wdata, ocmp, scmp, onreq, duty, tlvl} = '0;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd_chk(`LFM_A_SUMMARY, 8'h00);
      rd_chk(8'hA0, 8'h00);
      chk(fpin, 1'b1);
      // Latched CRC fault, count and report
      wr_reg(`LFM_A_MASK, 8'hFF);
      @(posedge clk_i);
      crc <= 1'b1;
      @(posedge clk_i);
      crc <= 1'b0;
      tick(3);
      chk(fpin, 1'b0);
      rd_chk(`LFM_A_CRC_CNT, 8'h01);
      wr_reg(`LFM_A_SUMMARY, 8'h10);
      rd_chk(`LFM_A_SUMMARY, 8'h10);
      wr_reg(`LFM_A_SUMMARY, 8'h00);
      tick(3);
      chk(fpin, 1'b1);
      // Open on switch 0, held until next PWM cycle
      wr_reg(`LFM_A_SW_CFG0, 8'h42);
      tick(1);
      chk(oth[1:0], 2'd2);
      @(posedge clk_i);
      ocmp <= 12'h001;
      tick(6);
      chk(byp, 12'h001);
      rd_chk(`LFM_A_OPEN_L, 8'h01);
      rd_chk(`LFM_A_SUMMARY, 8'h01);
      chk(fpin, 1'b0);
      @(posedge clk_i);
      ocmp <= 12'h000;
      tick(5);
      chk(byp, 12'h001);
      @(posedge clk_i);
      pst <= 1'b1;
      @(posedge clk_i);
      pst <= 1'b0;
      tick(3);
      chk(byp, 12'h000);
      wr_reg(`LFM_A_OPEN_L, 8'h00);
      wr_reg(`LFM_A_SUMMARY, 8'h00);
      tick(3);
      chk(fpin, 1'b1);
      // Short on switch 1 with its report mask off
      wr_reg(`LFM_A_MASK, 8'hFD);
      wr_reg(8'h85, 8'h8C);
      tick(1);
      chk(sth[7:4], 4'd3);
      @(posedge clk_i);
      scmp <= 12'h002;
      tick(4);
      @(posedge clk_i);
      onend <= 1'b1;
      @(posedge clk_i);
      onend <= 1'b0;
      scmp  <= 12'h000;
      rd_chk(`LFM_A_SHORT_L, 8'h02);
      rd_chk(`LFM_A_SUMMARY, 8'h00);
      chk(fpin, 1'b1);
      // Shutdown blocks switches until cooled
      @(posedge clk_i);
      onreq <= 12'hFFF;
      hot   <= 1'b1;
      tick(6);
      chk(byp, 12'h000);
      rd_chk(`LFM_A_SUMMARY, 8'h08);
      chk(fpin, 1'b0);
      @(posedge clk_i);
      hot <= 1'b0;
      tick(6);
      chk(byp, 12'h000);
      @(posedge clk_i);
      cool <= 1'b1;
      tick(6);
      chk(byp, 12'hFFF);
      rd_chk(`LFM_A_SUMMARY, 8'h08);
      // Thermal alarm stays latched after the temperature falls back
      wr_reg(`LFM_A_SUMMARY, 8'h00);
      wr_reg(`LFM_A_TEMP_CFG, 8'h02);
      tick(1);
      chk(tal, 2'h2);
      chk(fpin, 1'b1);
      @(posedge clk_i);
      tlvl <= 4'h4;
      tick(5);
      chk(fpin, 1'b0);
      @(posedge clk_i);
      tlvl <= 4'h0;
      tick(4);
      rd_chk(`LFM_A_SUMMARY, 8'h04);
      chk(fpin, 1'b0);
      wr_reg(`LFM_A_SUMMARY, 8'h00);
      tick(2);
      chk(fpin, 1'b1);
      // I2C faults set their own bits and the summary
      @(posedge clk_i);
      nack <= 1'b1;
      @(posedge clk_i);
      nack <= 1'b0;
      mism <= 1'b1;
      @(posedge clk_i);
      mism <= 1'b0;
      rd_chk(`LFM_A_I2C_STAT, 8'h03);
      wr_reg(`LFM_A_I2C_STAT, 8'h02);
      rd_chk(`LFM_A_I2C_STAT, 8'h02);
      // Duty errors latch only with the check enabled
      @(posedge clk_i);
      duty <= 12'h801;
      @(posedge clk_i);
      duty <= 12'h000;
      rd_chk(`LFM_A_DUTY_L, 8'h00);
      wr_reg(`LFM_A_DUTY_CTRL, 8'h01);
      @(posedge clk_i);
      duty <= 12'h801;
      @(posedge clk_i);
      duty <= 12'h000;
      rd_chk(`LFM_A_DUTY_L, 8'h01);
      rd_chk(`LFM_A_DUTY_H, 8'h08);
      rd_chk(`LFM_A_SUMMARY, 8'hC0);
      // Watchdog loss enters fail-safe only without good traffic
      @(posedge clk_i);
      strap <= 1'b1;
      efree <= 1'b1;
      tick(3);
      @(posedge clk_i);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt   <= 1'b0;
      efree <= 1'b0;
      tick(1);
      chk(fs, 1'b0);
      @(posedge clk_i);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      tick(1);
      chk(fs, 1'b1);
      rd_chk(`LFM_A_STATE, 8'h02);
      @(posedge clk_i);
      upd <= 1'b1;
      @(posedge clk_i);
      upd <= 1'b0;
      tick(1);
      chk(fs, 1'b0);
      rd_chk(`LFM_A_SUMMARY, 8'hE0);
      wr_reg(`LFM_A_SUMMARY, 8'hDF);
      rd_chk(`LFM_A_SUMMARY, 8'hC0);
      // Undervoltage in mid-run resets every register
      @(posedge clk_i);
      uvlo <= 1'b1;
      tick(4);
      chk(byp, 12'h000);
      @(posedge clk_i);
      uvlo <= 1'b0;
      tick(3);
      chk(tal, 2'h0);
      rd_chk(`LFM_A_SUMMARY, 8'h00);
      rd_chk(`LFM_A_I2C_STAT, 8'h00);
      chk(fpin, 1'b1);
      tally_and_finish();
   end
endmodule : led_fault_monitor_test
